// >>> design/liei_consts.vh
`ifndef LIEI_CONSTS_VH
`define LIEI_CONSTS_VH

// Register bus geometry.
`define LIEI_ADDR_W            16
`define LIEI_DATA_W            8

// Register byte addresses.
`define LIEI_ADDR_CFG          16'h0F02
`define LIEI_ADDR_CTRL3        16'h0F03
`define LIEI_ADDR_IRQ_EN       16'h0F04
`define LIEI_ADDR_LIVE         16'h0F05
`define LIEI_ADDR_IRQ_STAT     16'h0F06

// Field positions shared by enable, live and sticky status registers.
`define LIEI_BIT_DMO           6
`define LIEI_BIT_FIFO          5
`define LIEI_BIT_LOOP          3

// Control register three fields.
`define LIEI_BIT_INSERT        1
`define LIEI_BIT_CTRL3_SPARE   0

// Configuration register fields.
`define LIEI_TEST_LSB          0
`define LIEI_TEST_MSB          2
`define LIEI_LOOP_LSB          6
`define LIEI_LOOP_MSB          7

// Test pattern selector code under which a rise of the insert bit flips one transmitted QRSS bit.
`define LIEI_TEST_QRSS         3'h4

// Loop-code detection settings.
`define LIEI_LOOP_OFF          2'h0
`define LIEI_LOOP_UP           2'h1
`define LIEI_LOOP_DOWN         2'h2
`define LIEI_LOOP_AUTO         2'h3

// Jitter attenuator pointer width and the near-limit distance.
`define LIEI_PTR_W             6
`define LIEI_FIFO_LIMIT        6'h03

// Reset values.
`define LIEI_RST_BYTE          8'h00
`define LIEI_RST_TEST          3'h0
`define LIEI_RST_LOOP          2'h0

`endif

// >>> design/liei_line_ctrl.v
// How it works
// - With the test selector at the QRSS code, a 0-to-1 change of the insert bit that holds to the next line clock rise flips exactly one pattern bit.
// - The insert bit is sampled on each rising edge of the transmit line clock, and its rise is found in that sampling.
// - With the drive-monitor enable at bit 6 set, each change of the drive-monitor status in either direction raises an interrupt.
// - With the FIFO-limit enable at bit 5 set, an interrupt is raised when the read and write pointers come within three of each other.
// - With the loop-code enable at bit 3 set, an interrupt is raised when loop-code detection begins and again when it ends.
// - An enable of 0 suppresses its interrupt and 1 permits it, and all enables and the insert bit reset to 0.
// - Bit 7 of the enable register reads 0 and cannot be written, bits 4 and 2 have no function, and bit 0 of control three is unused.
// - The two-bit loop setting selects off, loop-up, loop-down, or automatic loop-up with remote loop-back.
`timescale 1ns/1ps
`include "liei_consts.vh"

module liei_line_ctrl (
  input  wire                      sys_clk,
  input  wire                      reset_n,
  input  wire [`LIEI_ADDR_W-1:0]   reg_addr,
  input  wire [`LIEI_DATA_W-1:0]   reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [`LIEI_DATA_W-1:0]   reg_rdata,
  input  wire                      transmit_line_clock,
  input  wire                      tx_qrss_data,
  output reg                       tx_line_data,
  input  wire                      drive_monitor_output,
  input  wire [`LIEI_PTR_W-1:0]    fifo_wr_ptr,
  input  wire [`LIEI_PTR_W-1:0]    fifo_rd_ptr,
  input  wire                      loop_up_seen,
  input  wire                      loop_down_seen,
  output reg                       loop_code_detect_status,
  output reg                       remote_loopback_active,
  output reg                       irq
);

  // Automatic loop-code sequencer states.
  localparam [1:0] AUTO_IDLE   = 2'h0;
  localparam [1:0] AUTO_ARMED  = 2'h1;
  localparam [1:0] AUTO_LOOPED = 2'h2;
  localparam [1:0] AUTO_DONE   = 2'h3;

  // Pointers within the limit in either direction, the limit itself included, count as near.
  function ptr_near;
    input [`LIEI_PTR_W-1:0] a;
    input [`LIEI_PTR_W-1:0] b;
    reg   [`LIEI_PTR_W-1:0] diff;
    begin
      diff     = a - b;
      ptr_near = (diff <= `LIEI_FIFO_LIMIT);
    end
  endfunction

  // Software-visible state.
  reg  [`LIEI_TEST_MSB:0]          tx_test_pattern_select;
  reg  [1:0]                       loop_mode;
  reg                              tx_bit_error_insert;
  reg                              ctrl3_spare;
  reg                              drive_monitor_change_irq_en;
  reg                              fifo_limit_irq_en;
  reg                              loop_code_change_irq_en;
  reg                              stat_dmo;
  reg                              stat_fifo;
  reg                              stat_loop;

  // Pin synchronisers; the second stage is looked at, and tclk_d and dmo_d hold it one more cycle for edge detection.
  reg                              tclk_m;
  reg                              tclk_s;
  reg                              tclk_d;
  reg                              qrss_m;
  reg                              qrss_s;
  reg                              dmo_m;
  reg                              dmo_s;
  reg                              dmo_d;
  reg                              lup_m;
  reg                              lup_s;
  reg                              ldn_m;
  reg                              ldn_s;

  // Line-side and event state.
  reg                              insert_sampled;
  reg                              fifo_near_d;
  reg                              loop_status_d;
  reg  [1:0]                       auto_state;
  reg  [1:0]                       next_auto_state;
  reg                              next_loop_status;
  reg                              next_loopback;

  wire                             wr_cfg;
  wire                             wr_ctrl3;
  wire                             wr_irq_en;
  wire                             rd_stat;
  wire                             tclk_rise;
  wire                             insert_rise;
  wire                             fifo_near;
  wire                             ev_dmo;
  wire                             ev_fifo;
  wire                             ev_loop;
  reg  [`LIEI_DATA_W-1:0]          next_rdata;

  assign wr_cfg    = reg_wr && (reg_addr == `LIEI_ADDR_CFG);
  assign wr_ctrl3  = reg_wr && (reg_addr == `LIEI_ADDR_CTRL3);
  assign wr_irq_en = reg_wr && (reg_addr == `LIEI_ADDR_IRQ_EN);
  assign rd_stat   = reg_rd && (reg_addr == `LIEI_ADDR_IRQ_STAT);

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tclk_m <= 1'b0;
      tclk_s <= 1'b0;
      tclk_d <= 1'b0;
      qrss_m <= 1'b0;
      qrss_s <= 1'b0;
      dmo_m  <= 1'b0;
      dmo_s  <= 1'b0;
      dmo_d  <= 1'b0;
      lup_m  <= 1'b0;
      lup_s  <= 1'b0;
      ldn_m  <= 1'b0;
      ldn_s  <= 1'b0;
    end else begin
      tclk_m <= transmit_line_clock;
      tclk_s <= tclk_m;
      tclk_d <= tclk_s;
      qrss_m <= tx_qrss_data;
      qrss_s <= qrss_m;
      dmo_m  <= drive_monitor_output;
      dmo_s  <= dmo_m;
      dmo_d  <= dmo_s;
      lup_m  <= loop_up_seen;
      lup_s  <= lup_m;
      ldn_m  <= loop_down_seen;
      ldn_s  <= ldn_m;
    end
  end

  // Register writes. Bit 7 and bits 4 and 2 of the enable register hold no storage.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_test_pattern_select      <= `LIEI_RST_TEST;
      loop_mode                   <= `LIEI_RST_LOOP;
      tx_bit_error_insert         <= 1'b0;
      ctrl3_spare                 <= 1'b0;
      drive_monitor_change_irq_en <= 1'b0;
      fifo_limit_irq_en           <= 1'b0;
      loop_code_change_irq_en     <= 1'b0;
    end else begin
      if (wr_cfg) begin
        tx_test_pattern_select <= reg_wdata[`LIEI_TEST_MSB:`LIEI_TEST_LSB];
        loop_mode              <= reg_wdata[`LIEI_LOOP_MSB:`LIEI_LOOP_LSB];
      end
      if (wr_ctrl3) begin
        tx_bit_error_insert <= reg_wdata[`LIEI_BIT_INSERT];
        ctrl3_spare         <= reg_wdata[`LIEI_BIT_CTRL3_SPARE];
      end
      if (wr_irq_en) begin
        drive_monitor_change_irq_en <= reg_wdata[`LIEI_BIT_DMO];
        fifo_limit_irq_en           <= reg_wdata[`LIEI_BIT_FIFO];
        loop_code_change_irq_en     <= reg_wdata[`LIEI_BIT_LOOP];
      end
    end
  end

  // The insert bit lives in the system domain but is judged only at line clock edges,
  // so a 0-1-0 pulse shorter than one line bit can be missed; holding 1 to the next line clock rise avoids that.
  assign tclk_rise   = tclk_s & ~tclk_d;
  assign insert_rise = tx_bit_error_insert & ~insert_sampled;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      insert_sampled <= 1'b0;
      tx_line_data   <= 1'b0;
    end else if (tclk_rise) begin
      insert_sampled <= tx_bit_error_insert;
      if (insert_rise && (tx_test_pattern_select == `LIEI_TEST_QRSS)) begin
        tx_line_data <= ~qrss_s;
      end else begin
        tx_line_data <= qrss_s;
      end
    end
  end

  // Loop-code detection status per setting.
  always @* begin
    next_auto_state  = auto_state;
    next_loop_status = 1'b0;
    next_loopback    = 1'b0;
    case (loop_mode)
      `LIEI_LOOP_OFF: begin
        next_auto_state = AUTO_IDLE;
      end
      `LIEI_LOOP_UP: begin
        next_auto_state  = AUTO_IDLE;
        next_loop_status = lup_s;
      end
      `LIEI_LOOP_DOWN: begin
        next_auto_state  = AUTO_IDLE;
        next_loop_status = ldn_s;
      end
      default: begin
        case (auto_state)
          AUTO_IDLE: begin
            next_auto_state = AUTO_ARMED;
          end
          AUTO_ARMED: begin
            if (lup_s) begin
              next_auto_state  = AUTO_LOOPED;
              next_loop_status = 1'b1;
              next_loopback    = 1'b1;
            end
          end
          AUTO_LOOPED: begin
            next_loop_status = 1'b1;
            next_loopback    = 1'b1;
            if (ldn_s) begin
              next_auto_state  = AUTO_DONE;
              next_loop_status = 1'b0;
              next_loopback    = 1'b0;
            end
          end
          AUTO_DONE: begin
            next_auto_state = AUTO_DONE;
          end
          default: begin
            next_auto_state = AUTO_IDLE;
          end
        endcase
      end
    endcase
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      auto_state              <= AUTO_IDLE;
      loop_code_detect_status <= 1'b0;
      remote_loopback_active  <= 1'b0;
      loop_status_d           <= 1'b0;
      fifo_near_d             <= 1'b0;
    end else begin
      auto_state              <= next_auto_state;
      loop_code_detect_status <= next_loop_status;
      remote_loopback_active  <= next_loopback;
      loop_status_d           <= loop_code_detect_status;
      fifo_near_d             <= fifo_near;
    end
  end

  // Pointers are taken from logic on this clock and need no synchroniser.
  assign fifo_near = ptr_near(fifo_wr_ptr, fifo_rd_ptr) | ptr_near(fifo_rd_ptr, fifo_wr_ptr);

  assign ev_dmo  = drive_monitor_change_irq_en & (dmo_s ^ dmo_d);
  assign ev_fifo = fifo_limit_irq_en & fifo_near & ~fifo_near_d;
  assign ev_loop = loop_code_change_irq_en &
                   (loop_code_detect_status ^ loop_status_d);

  // Sticky bits clear on a status read, but an event in the same cycle wins.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_dmo  <= 1'b0;
      stat_fifo <= 1'b0;
      stat_loop <= 1'b0;
    end else begin
      stat_dmo  <= ev_dmo  | (stat_dmo  & ~rd_stat);
      stat_fifo <= ev_fifo | (stat_fifo & ~rd_stat);
      stat_loop <= ev_loop | (stat_loop & ~rd_stat);
    end
  end

  // Read mux; unmapped addresses and reserved bits read as zero.
  always @* begin
    next_rdata = `LIEI_RST_BYTE;
    case (reg_addr)
      `LIEI_ADDR_CFG: begin
        next_rdata[`LIEI_TEST_MSB:`LIEI_TEST_LSB] = tx_test_pattern_select;
        next_rdata[`LIEI_LOOP_MSB:`LIEI_LOOP_LSB] = loop_mode;
      end
      `LIEI_ADDR_CTRL3: begin
        next_rdata[`LIEI_BIT_INSERT]      = tx_bit_error_insert;
        next_rdata[`LIEI_BIT_CTRL3_SPARE] = ctrl3_spare;
      end
      `LIEI_ADDR_IRQ_EN: begin
        next_rdata[`LIEI_BIT_DMO]  = drive_monitor_change_irq_en;
        next_rdata[`LIEI_BIT_FIFO] = fifo_limit_irq_en;
        next_rdata[`LIEI_BIT_LOOP] = loop_code_change_irq_en;
      end
      `LIEI_ADDR_LIVE: begin
        next_rdata[`LIEI_BIT_DMO]  = dmo_s;
        next_rdata[`LIEI_BIT_FIFO] = fifo_near;
        next_rdata[`LIEI_BIT_LOOP] = loop_code_detect_status;
      end
      `LIEI_ADDR_IRQ_STAT: begin
        next_rdata[`LIEI_BIT_DMO]  = stat_dmo;
        next_rdata[`LIEI_BIT_FIFO] = stat_fifo;
        next_rdata[`LIEI_BIT_LOOP] = stat_loop;
      end
      default: begin
        next_rdata = `LIEI_RST_BYTE;
      end
    endcase
  end

  // Read data stands for one cycle only and is zero otherwise.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `LIEI_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= `LIEI_RST_BYTE;
    end
  end

  // The enables also mask the latched bits, so disabling one drops the request at once.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (stat_dmo  & drive_monitor_change_irq_en) |
             (stat_fifo & fifo_limit_irq_en) |
             (stat_loop & loop_code_change_irq_en);
    end
  end

endmodule // liei_line_ctrl

// >>> testbench/liei_line_ctrl_checker.sv
`timescale 1ns/1ps
`include "liei_consts.vh"
module liei_line_ctrl_checker (
  input wire        sys_clk,
  input wire        reset_n,
  input wire [15:0] reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        transmit_line_clock,
  input wire        tx_line_data,
  input wire        loop_code_detect_status,
  input wire        remote_loopback_active,
  input wire        irq
);
  // A write or a status read may drop the request, so those cycles are exempt.
  wire touch  = reg_wr | (reg_rd & (reg_addr == `LIEI_ADDR_IRQ_STAT));
  wire rd_map = reg_rd & (reg_addr >= `LIEI_ADDR_CFG) & (reg_addr <= `LIEI_ADDR_IRQ_STAT);
  wire rd_en  = reg_rd & (reg_addr == `LIEI_ADDR_IRQ_EN);
  wire rd_c3  = reg_rd & (reg_addr == `LIEI_ADDR_CTRL3);
  wire wr_off = reg_wr & (reg_addr == `LIEI_ADDR_IRQ_EN) & (reg_wdata == 8'h00);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_rst_idle;
    !$past(reset_n) |-> !irq && !tx_line_data && !loop_code_detect_status
      && !remote_loopback_active && reg_rdata == 8'h00;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs busy after reset");
  property p_rd_quiet;
    !$past(rd_map) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside a read");
  property p_en_rsvd;
    $past(rd_en) |-> (reg_rdata & 8'h97) == 8'h00;
  endproperty
  a_en_rsvd: assert property (p_en_rsvd) else $error("enable spare bits set");
  property p_c3_rsvd;
    $past(rd_c3) |-> reg_rdata[7:2] == 6'h00;
  endproperty
  a_c3_rsvd: assert property (p_c3_rsvd) else $error("control three spare bits set");
  property p_irq_hold;
    irq && !touch && !$past(touch) |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped unserviced");
  property p_mask_off;
    $past(wr_off) |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("interrupt with enables off");
  property p_auto_pair;
    remote_loopback_active |-> loop_code_detect_status;
  endproperty
  a_auto_pair: assert property (p_auto_pair) else $error("loopback without detect");
  property p_tx_edge;
    $changed(tx_line_data) |-> $past(transmit_line_clock, 2) && !$past(transmit_line_clock, 5);
  endproperty
  a_tx_edge: assert property (p_tx_edge) else $error("line data moved off a line edge");
  c_irq: cover property ($rose(irq));
  c_loopback: cover property ($rose(remote_loopback_active));
  c_insert: cover property ($changed(tx_line_data));
endmodule // liei_line_ctrl_checker

bind liei_line_ctrl liei_line_ctrl_checker i_chk (
  .sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .transmit_line_clock, .tx_line_data, .loop_code_detect_status,
  .remote_loopback_active, .irq
);

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`include "liei_consts.vh"
module tb_top;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        transmit_line_clock = 1'b0;
  logic        tx_qrss_data = 1'b0;
  logic        drive_monitor_output = 1'b0;
  logic [5:0]  fifo_wr_ptr = 6'h00;
  logic [5:0]  fifo_rd_ptr = 6'h00;
  logic        loop_up_seen = 1'b0;
  logic        loop_down_seen = 1'b0;
  logic        flip_d = 1'b0;
  wire  [7:0]  reg_rdata;
  wire         tx_line_data;
  wire         loop_code_detect_status;
  wire         remote_loopback_active;
  wire         irq;
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n_flip = 0;
  int          m_cfg = 0;
  int          m_c3 = 0;
  int          m_en = 0;
  int          m_stat = 0;
  int          m_loop = 0;
  int          seed;
  int          p;
  int          ptab [20] = '{10, 20, 16, 20, 17, 20, 30, 20, 23, 20,
                             24, 20, 30, 20, 62, 1, 30, 20, 1, 62};

  liei_line_ctrl i_dut (
    .sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .transmit_line_clock, .tx_qrss_data, .tx_line_data, .drive_monitor_output,
    .fifo_wr_ptr, .fifo_rd_ptr, .loop_up_seen, .loop_down_seen,
    .loop_code_detect_status, .remote_loopback_active, .irq
  );

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // The line clock is slow beside the bus so each inserted bit stands long enough to count.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    transmit_line_clock <= cyc[3];
    flip_d <= tx_line_data !== tx_qrss_data;
    if ((tx_line_data !== tx_qrss_data) && !flip_d)
      n_flip++;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  function automatic int near();
    int d;
    d = (fifo_wr_ptr - fifo_rd_ptr) & 63;
    return (d <= 3 || d >= 61) ? 1 : 0;
  endfunction

  function automatic int exp_rd(input int a);
    case (a)
      `LIEI_ADDR_CFG: return m_cfg;
      `LIEI_ADDR_CTRL3: return m_c3;
      `LIEI_ADDR_IRQ_EN: return m_en;
      `LIEI_ADDR_LIVE: return (drive_monitor_output ? 64 : 0) + near() * 32 + m_loop * 8;
      `LIEI_ADDR_IRQ_STAT: return m_stat;
      default: return 0;
    endcase
  endfunction

  task automatic chk_b(input logic [7:0] got, input int exp);
    checked++;
    if (got !== exp[7:0]) begin
      n_errors++;
      $display("mismatch at %0t: byte %h, expected %h", $time, got, exp[7:0]);
    end
  endtask

  task automatic chk_f(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input int a, input int d);
    reg_addr <= a[15:0];
    reg_wdata <= d[7:0];
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
    if (a == `LIEI_ADDR_CFG)
      m_cfg = d & 8'hC7;
    if (a == `LIEI_ADDR_CTRL3)
      m_c3 = d & 3;
    if (a == `LIEI_ADDR_IRQ_EN)
      m_en = d & 8'h68;
  endtask

  task automatic rd(input int a);
    reg_addr <= a[15:0];
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk_b(reg_rdata, exp_rd(a));
    if (a == `LIEI_ADDR_IRQ_STAT)
      m_stat = 0;
    @(posedge sys_clk);
  endtask

  // Waits out the pin synchronisers, then services the status like a driver would.
  task automatic settle(input int b);
    tick(10);
    if (m_en & b)
      m_stat = m_stat | b;
    chk_f(irq, (m_stat & m_en) != 0);
    rd(`LIEI_ADDR_IRQ_STAT);
    tick(2);
    chk_f(irq, 1'b0);
  endtask

  task automatic ins(input int cfg, input int clr, input int exp);
    int r;
    r = $urandom;
    tx_qrss_data <= r[0];
    wr(`LIEI_ADDR_CFG, cfg);
    rd(`LIEI_ADDR_CFG);
    if (clr)
      wr(`LIEI_ADDR_CTRL3, 0);
    tick(40);
    n_flip = 0;
    wr(`LIEI_ADDR_CTRL3, 2);
    tick(40);
    chk_b(n_flip[7:0], exp);
  endtask

  task automatic print_verdict;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    seed = $urandom(19);
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    for (int a = 16'h0F01; a <= 16'h0F07; a++)
      rd(a);
    wr(`LIEI_ADDR_IRQ_EN, 8'hFF);
    rd(`LIEI_ADDR_IRQ_EN);
    repeat (12) begin
      wr(`LIEI_ADDR_IRQ_EN, $urandom);
      wr(`LIEI_ADDR_CTRL3, $urandom);
      wr(16'h0F07, $urandom);
      rd(`LIEI_ADDR_IRQ_EN);
      rd(`LIEI_ADDR_CTRL3);
      rd(16'h0F07);
    end
    wr(`LIEI_ADDR_CTRL3, 0);
    wr(`LIEI_ADDR_IRQ_EN, 8'h40);
    for (int i = 0; i < 4; i++) begin
      drive_monitor_output <= ~drive_monitor_output;
      if (i == 2)
        wr(`LIEI_ADDR_IRQ_EN, 8'h00);
      settle(64);
      rd(`LIEI_ADDR_LIVE);
    end
    wr(`LIEI_ADDR_IRQ_EN, 8'h40);
    drive_monitor_output <= ~drive_monitor_output;
    tick(10);
    m_stat = 64;
    chk_f(irq, 1'b1);
    wr(`LIEI_ADDR_IRQ_EN, 8'h00);
    tick(1);
    chk_f(irq, 1'b0);
    rd(`LIEI_ADDR_IRQ_STAT);
    wr(`LIEI_ADDR_IRQ_EN, 8'h20);
    for (int i = 0; i < 20; i += 2) begin
      p = near();
      fifo_wr_ptr <= ptab[i][5:0];
      fifo_rd_ptr <= ptab[i + 1][5:0];
      tick(1);
      settle((near() && !p) ? 32 : 0);
      rd(`LIEI_ADDR_LIVE);
    end
    wr(`LIEI_ADDR_IRQ_EN, 8'h08);
    for (int m = 0; m < 3; m++) begin
      wr(`LIEI_ADDR_CFG, m * 64);
      for (int v = 1; v >= 0; v--) begin
        loop_up_seen <= v[0];
        loop_down_seen <= v[0];
        m_loop = (m != 0) ? v : 0;
        settle((m != 0) ? 8 : 0);
        rd(`LIEI_ADDR_LIVE);
      end
    end
    wr(`LIEI_ADDR_CFG, 8'hC0);
    tick(3);
    loop_up_seen <= 1'b1;
    m_loop = 1;
    settle(8);
    chk_f(remote_loopback_active, 1'b1);
    loop_up_seen <= 1'b0;
    tick(10);
    chk_f(loop_code_detect_status, 1'b1);
    loop_down_seen <= 1'b1;
    m_loop = 0;
    settle(8);
    chk_f(remote_loopback_active, 1'b0);
    loop_down_seen <= 1'b0;
    for (int c = 0; c < 8; c++)
      ins(c, 1, c == 4);
    ins(4, 0, 0);
    print_verdict();
  end
endmodule // tb_top
